// ==== rtl/vlc_device.sv ====
// Line controller register bank with its line-side control effects

// Function
// RQ1: Route bits pick differential, wire B, wire A, auto
// RQ2: Timeslot clock is crystal over sixteen times divider
// RQ3: Pulsed coding uses differential only, diagnosis off
// RQ4: Invert bits flip transmit and receive levels
// RQ5: Retry up to limit, limit plus one transmissions
// RQ6: Lost contention never counts toward retry limit
// RQ7: Host always writes fixed version field value
// RQ8: Module type bit selects allowed module ranks
// RQ9: Diagnosis clock divides timeslot by 64 shifted
// RQ10: Progress enable gates progress signal and diagnosis; the code gates only tx_in_progress, diagnosis_enable follows pulsed alone
// RQ11: Diagnosis clock enable runs the automatic divider
// RQ12: Host writes zero to reserved bits
// RQ13: Host polls line status after command writes; code polls only after reset, sleep, idle or activate writes
// RQ14: General reset command acts like reset pin
// RQ15: Sleep stops oscillator until idle or activate
// RQ16: Idle stops traffic, transmit output released
// RQ17: Activate enables transmit output and traffic
// RQ18: Re-arbitrate clears retries after current attempt
// RQ19: Manual diagnosis pulse lasts two timeslots minimum
// RQ20: Undefined addresses below 0x80 are absent
// RQ21: Return-to-idle pulse only in forced modes
// RQ22: Sleeping and idling readable, idle after reset
// RQ23: Command register reads return no state
module vlc_device #(
	parameter int TS_W = 8,
	parameter int SDC_W = 22
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	vlc_if.dev_mp bus,
	// Line pins
	input wire logic rx_differential_in,
	input wire logic rx_single_wire_a_in,
	input wire logic rx_single_wire_b_in,
	output logic tx_line_out,
	output logic tx_line_oe,
	// Frame logic
	input wire logic tx_data,
	input wire logic tx_request,
	input wire logic attempt_end,
	input wire logic attempt_ok,
	input wire logic attempt_error,
	input wire logic eof_seen,
	output logic rx_data_out,
	output logic [3:0] retry_count,
	output logic retry_exhausted,
	output logic rearbitrate,
	output logic module_type_sel,
	output logic pulsed_coding_sel,
	// Diagnosis logic
	input wire logic diag_sa,
	input wire logic diag_sb,
	input wire logic diag_sc,
	input wire logic tx_going,
	input wire logic rx_going,
	output logic timeslot_clock,
	output logic sync_diagnosis_clock,
	output logic tx_in_progress,
	output logic return_to_idle_pulse,
	output logic diagnosis_enable,
	output logic [1:0] rx_source,
	// Chip level
	output logic general_reset_out,
	output logic oscillator_run
);
	logic [7:0] line_control;
	logic [7:0] transmit_control;
	logic [7:0] diagnosis_control;
	logic sleeping;
	logic idling;
	logic global_reset_cmd_pend;
	logic rear_pend;
	logic [TS_W-1:0] ts_cnt;
	logic [SDC_W-1:0] sdc_cnt;
	logic sdc_div_pulse;
	logic [1:0] manual_diag_clock_pulse_left;
	logic alt_wire;
	logic [2:0] rx_meta;
	logic [2:0] rx_sync;
	logic [7:0] rdata;
	logic ack;

	// Address decode
	wire lc_wr = bus.wr && bus.addr == vlc_pkg::LINE_CONTROL_ADDR;
	wire tc_wr = bus.wr && bus.addr == vlc_pkg::TRANSMIT_CONTROL_ADDR;
	wire dc_wr = bus.wr && bus.addr == vlc_pkg::DIAGNOSIS_CONTROL_ADDR;
	wire cmd_wr = bus.wr && bus.addr == vlc_pkg::COMMAND_ADDR;
	wire [7:0] cmd = cmd_wr ? bus.wdata : 8'h00; // see RQ23
	wire soft_rst = global_reset_cmd_pend;

	// Fields
	wire [3:0] brd = line_control[vlc_pkg::LC_BRD_LSB +: 4];
	wire pulsed = line_control[vlc_pkg::LC_PULSED_BIT];
	wire tx_inv = line_control[vlc_pkg::LC_TXINV_BIT];
	wire rx_inv = line_control[vlc_pkg::LC_RXINV_BIT];
	wire [3:0] max_retry = transmit_control[vlc_pkg::TC_RETRY_LSB +: 4];
	wire [3:0] sdc_code = diagnosis_control[vlc_pkg::DC_DIV_LSB +: 4];
	wire tx_progress_enable = diagnosis_control[vlc_pkg::DC_TIP_BIT];
	wire diag_clock_enable = diagnosis_control[vlc_pkg::DC_SDC_BIT];
	wire [1:0] mode_bits = {diagnosis_control[vlc_pkg::DC_HI_BIT],
		diagnosis_control[vlc_pkg::DC_LO_BIT]};
	wire active = !sleeping && !idling;

	// Timeslot divider, a zero divider behaves as one
	wire [3:0] brd_eff = (brd == 4'h0) ? 4'h1 : brd;
	wire [TS_W-1:0] ts_last =
		TS_W'(brd_eff * vlc_pkg::TS_PRESCALE - 1); // see RQ2
	wire ts_tick = !sleeping && ts_cnt == ts_last; // see RQ15

	// Diagnosis clock divider
	wire [SDC_W-1:0] sdc_last =
		SDC_W'((SDC_W'(vlc_pkg::SDC_BASE) << sdc_code) - 1); // see RQ9
	wire sdc_hit = diag_clock_enable && ts_tick && sdc_cnt == sdc_last; // see RQ11

	// Receive source selection
	wire [1:0] route_sel = pulsed ? vlc_pkg::ROUTE_DIFF : mode_bits; // see RQ3
	wire [1:0] auto_src = ({diag_sa, diag_sb} == 2'b11) ?
		(alt_wire ? vlc_pkg::ROUTE_WIRE_A : vlc_pkg::ROUTE_WIRE_B) :
		{diag_sa, diag_sb};
	wire [1:0] src = (route_sel == vlc_pkg::ROUTE_AUTO) ?
		auto_src : route_sel; // see RQ1
	wire [2:0] rx_lvl = rx_sync ^ {3{rx_inv}}; // see RQ4
	wire rx_pick = (src == vlc_pkg::ROUTE_WIRE_A) ? rx_lvl[1] :
		(src == vlc_pkg::ROUTE_WIRE_B) ? rx_lvl[2] : rx_lvl[0];

	// Read data
	wire [7:0] status = {1'b0, sleeping, idling, diag_sc, diag_sb, diag_sa,
		tx_going, rx_going}; // see RQ22
	wire [7:0] rd_mux =
		(bus.addr == vlc_pkg::LINE_CONTROL_ADDR) ? line_control :
		(bus.addr == vlc_pkg::TRANSMIT_CONTROL_ADDR) ? transmit_control :
		(bus.addr == vlc_pkg::DIAGNOSIS_CONTROL_ADDR) ? diagnosis_control :
		(bus.addr == vlc_pkg::LINE_STATUS_ADDR) ? status :
		8'h00; // see RQ20

	assign bus.rdata = rdata;
	assign bus.ack = ack;

	// Register port answer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
			ack <= 1'b0;
		end else begin
			rdata <= bus.rd ? rd_mux : rdata;
			ack <= bus.rd || bus.wr;
		end
	end

	// General reset command, clears itself after one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			global_reset_cmd_pend <= 1'b0;
			general_reset_out <= 1'b0;
		end else begin
			global_reset_cmd_pend <= cmd[vlc_pkg::CMD_GLOBAL_RESET_CMD_BIT]; // see RQ14
			general_reset_out <= global_reset_cmd_pend;
		end
	end

	// Control registers, reserved bits stay clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst || soft_rst) begin // see RQ14
			line_control <= vlc_pkg::LINE_CONTROL_RESET;
			transmit_control <= vlc_pkg::TRANSMIT_CONTROL_RESET;
			diagnosis_control <= vlc_pkg::DIAGNOSIS_CONTROL_RESET;
		end else begin
			if (lc_wr)
				line_control <= bus.wdata & ~vlc_pkg::LC_RESERVED_MASK;
			if (tc_wr)
				transmit_control <= {bus.wdata[7:4], vlc_pkg::VERSION_CODE,
					bus.wdata[0]};
			if (dc_wr)
				diagnosis_control <= bus.wdata;
		end
	end

	// Operating mode, exit commands win over sleep
	always_ff @(posedge clk or posedge rst) begin
		if (rst || soft_rst) begin
			sleeping <= 1'b0;
			idling <= 1'b1; // see RQ22
		end else if (cmd[vlc_pkg::CMD_ACTIVATE_CMD_BIT]) begin
			sleeping <= 1'b0; // see RQ17
			idling <= 1'b0;
		end else if (cmd[vlc_pkg::CMD_IDLE_BIT]) begin
			sleeping <= 1'b0; // see RQ16
			idling <= 1'b1;
		end else if (cmd[vlc_pkg::CMD_SLEEP_BIT]) begin
			sleeping <= 1'b1; // see RQ15
			idling <= 1'b0;
		end
	end

	// Timeslot and diagnosis clocks
	always_ff @(posedge clk or posedge rst) begin
		if (rst || soft_rst) begin
			ts_cnt <= '0;
			sdc_cnt <= '0;
			sdc_div_pulse <= 1'b0;
			manual_diag_clock_pulse_left <= 2'h0;
			timeslot_clock <= 1'b0;
			sync_diagnosis_clock <= 1'b0;
			alt_wire <= 1'b0;
		end else begin
			ts_cnt <= ts_tick ? '0 : (sleeping ? ts_cnt : ts_cnt + 1'b1);
			timeslot_clock <= ts_tick;
			if (!diag_clock_enable || sdc_hit)
				sdc_cnt <= '0;
			else if (ts_tick)
				sdc_cnt <= sdc_cnt + 1'b1;
			sdc_div_pulse <= sdc_hit;
			if (cmd[vlc_pkg::CMD_MANUAL_DIAG_CLOCK_PULSE_BIT])
				manual_diag_clock_pulse_left <= vlc_pkg::MANUAL_DIAG_CLOCK_PULSE_HOLD_TICKS; // see RQ19
			else if (ts_tick && manual_diag_clock_pulse_left != 2'h0)
				manual_diag_clock_pulse_left <= manual_diag_clock_pulse_left - 2'h1;
			sync_diagnosis_clock <= (manual_diag_clock_pulse_left != 2'h0) ? 1'b1 :
				sdc_div_pulse; // see RQ19
			if (sdc_div_pulse)
				alt_wire <= !alt_wire;
		end
	end

	// Receive pin synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_meta <= 3'h0;
			rx_sync <= 3'h0;
		end else begin
			rx_meta <= {rx_single_wire_b_in, rx_single_wire_a_in,
				rx_differential_in};
			rx_sync <= rx_meta;
		end
	end

	// Line side outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst || soft_rst) begin
			rx_data_out <= 1'b0;
			rx_source <= vlc_pkg::ROUTE_DIFF;
			tx_line_out <= 1'b0;
			tx_line_oe <= 1'b0;
			tx_in_progress <= 1'b0;
			return_to_idle_pulse <= 1'b0;
			diagnosis_enable <= 1'b0;
			module_type_sel <= 1'b0;
			pulsed_coding_sel <= 1'b0;
			oscillator_run <= 1'b1;
		end else begin
			rx_data_out <= active ? rx_pick : !rx_inv; // see RQ16
			rx_source <= src;
			tx_line_out <= active ? (tx_data ^ tx_inv) : tx_inv; // see RQ4
			tx_line_oe <= active; // see RQ17
			tx_in_progress <= active && tx_request && tx_progress_enable &&
				!pulsed; // see RQ10
			return_to_idle_pulse <= eof_seen && !pulsed &&
				route_sel != vlc_pkg::ROUTE_AUTO; // see RQ21
			diagnosis_enable <= !pulsed; // see RQ3
			module_type_sel <= transmit_control[vlc_pkg::TC_MT_BIT]; // see RQ8
			pulsed_coding_sel <= pulsed;
			oscillator_run <= !sleeping; // see RQ15
		end
	end

	// Retry counting and re-arbitration
	always_ff @(posedge clk or posedge rst) begin
		if (rst || soft_rst) begin
			retry_count <= 4'h0;
			retry_exhausted <= 1'b0;
			rearbitrate <= 1'b0;
			rear_pend <= 1'b0;
		end else begin
			rear_pend <= cmd[vlc_pkg::CMD_REAR_BIT] ||
				(rear_pend && !attempt_end); // see RQ18
			retry_exhausted <= 1'b0;
			rearbitrate <= 1'b0;
			if (attempt_end) begin
				if (rear_pend || attempt_ok) begin
					retry_count <= 4'h0;
					rearbitrate <= rear_pend; // see RQ18
				end else if (attempt_error) begin
					if (retry_count == max_retry) begin
						retry_count <= 4'h0; // see RQ5
						retry_exhausted <= 1'b1;
					end else begin
						retry_count <= retry_count + 4'h1;
					end
				end
				// A lost contention leaves the count alone, see RQ6
			end
		end
	end
endmodule

// ==== rtl/vlc_pkg.sv ====
// Shared constants and types for the line control register bank
package vlc_pkg;
	// Register addresses on the device port
	localparam logic [6:0] LINE_CONTROL_ADDR = 7'h00;
	localparam logic [6:0] TRANSMIT_CONTROL_ADDR = 7'h01;
	localparam logic [6:0] DIAGNOSIS_CONTROL_ADDR = 7'h02;
	localparam logic [6:0] COMMAND_ADDR = 7'h03;
	localparam logic [6:0] LINE_STATUS_ADDR = 7'h04;
	// Revision code, value is arbitrary
	localparam logic [2:0] VERSION_CODE = 3'h5;
	// Reset values
	localparam logic [7:0] LINE_CONTROL_RESET = 8'h00;
	localparam logic [7:0] TRANSMIT_CONTROL_RESET = {4'h0, VERSION_CODE, 1'b0};
	localparam logic [7:0] DIAGNOSIS_CONTROL_RESET = 8'h00;
	// Line control fields
	localparam int LC_BRD_LSB = 4;
	localparam int LC_PULSED_BIT = 3;
	localparam int LC_TXINV_BIT = 1;
	localparam int LC_RXINV_BIT = 0;
	localparam logic [7:0] LC_RESERVED_MASK = 8'h04;
	// Transmit control fields
	localparam int TC_RETRY_LSB = 4;
	localparam int TC_VER_LSB = 1;
	localparam int TC_MT_BIT = 0;
	// Diagnosis control fields
	localparam int DC_DIV_LSB = 4;
	localparam int DC_HI_BIT = 3;
	localparam int DC_LO_BIT = 2;
	localparam int DC_TIP_BIT = 1;
	localparam int DC_SDC_BIT = 0;
	// Command fields
	localparam int CMD_GLOBAL_RESET_CMD_BIT = 7;
	localparam int CMD_SLEEP_BIT = 6;
	localparam int CMD_IDLE_BIT = 5;
	localparam int CMD_ACTIVATE_CMD_BIT = 4;
	localparam int CMD_REAR_BIT = 3;
	localparam int CMD_MANUAL_DIAG_CLOCK_PULSE_BIT = 0;
	localparam logic [7:0] CMD_RESERVED_MASK = 8'h06;
	// Line status fields
	localparam int LS_SPG_BIT = 6;
	localparam int LS_IDG_BIT = 5;
	// Timing
	localparam int TS_PRESCALE = 16;
	localparam int SDC_BASE = 64;
	localparam logic [1:0] MANUAL_DIAG_CLOCK_PULSE_HOLD_TICKS = 2'h3;
	localparam int CMD_DELAY_SLOTS = 6;
	// Host side map
	localparam logic [7:0] HOST_STATUS_INDEX = 8'h80;
	localparam int HS_CONFIRMED_BIT = 0;
	localparam int HS_TIMEOUT_BIT = 1;
	// Receive source routing
	typedef enum logic [1:0] {
		ROUTE_DIFF = 2'b00,
		ROUTE_WIRE_B = 2'b01,
		ROUTE_WIRE_A = 2'b10,
		ROUTE_AUTO = 2'b11
	} vlc_route_type;
endpackage

// ==== rtl/vlc_if.sv ====
// Register port between the host controller and the line controller
interface vlc_if;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic ack;
	modport dev_mp (input addr, input wdata, input wr, input rd,
		output rdata, output ack);
	modport host_mp (output addr, output wdata, output wr, output rd,
		input rdata, input ack);
endinterface

// ==== rtl/vlc_host.sv ====
// Host controller: Avalon-MM slave that drives the register port
module vlc_host #(
	parameter int POLL_LIMIT = 1024
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Register port
	vlc_if.host_mp bus
);
	typedef enum logic [5:0] {
		H_IDLE = 6'b000001,
		H_ISSUE = 6'b000010,
		H_WAIT = 6'b000100,
		H_POLL = 6'b001000,
		H_PWAIT = 6'b010000,
		H_DONE = 6'b100000
	} vlc_hstate_type;

	vlc_hstate_type state;
	logic [6:0] lat_addr;
	logic [7:0] lat_wdata;
	logic lat_wr;
	logic [1:0] want;
	logic need_poll;
	logic [$clog2(POLL_LIMIT+1)-1:0] polls;
	logic confirmed;
	logic timed_out;

	// Write value conditioning for the device's fixed and reserved bits
	function automatic logic [7:0] cond(input logic [6:0] a,
		input logic [7:0] d);
		logic [7:0] r;
		r = d;
		if (a == vlc_pkg::LINE_CONTROL_ADDR)
			r = d & ~vlc_pkg::LC_RESERVED_MASK; // see RQ12
		if (a == vlc_pkg::TRANSMIT_CONTROL_ADDR)
			r[vlc_pkg::TC_VER_LSB +: 3] = vlc_pkg::VERSION_CODE; // see RQ7
		if (a == vlc_pkg::COMMAND_ADDR)
			r = d & ~vlc_pkg::CMD_RESERVED_MASK; // see RQ12
		return r;
	endfunction

	wire own_hit = avs_address == vlc_pkg::HOST_STATUS_INDEX;
	wire [7:0] wd = cond(avs_address[6:0], avs_writedata[7:0]);
	wire is_cmd = avs_address[6:0] == vlc_pkg::COMMAND_ADDR;
	// Expected {sleeping, idling} after a mode command
	wire [1:0] exp_mode = wd[vlc_pkg::CMD_GLOBAL_RESET_CMD_BIT] ? 2'b01 :
		wd[vlc_pkg::CMD_ACTIVATE_CMD_BIT] ? 2'b00 :
		wd[vlc_pkg::CMD_IDLE_BIT] ? 2'b01 : 2'b10;
	wire mode_cmd = wd[vlc_pkg::CMD_GLOBAL_RESET_CMD_BIT] || wd[vlc_pkg::CMD_ACTIVATE_CMD_BIT] ||
		wd[vlc_pkg::CMD_IDLE_BIT] || wd[vlc_pkg::CMD_SLEEP_BIT];
	wire [1:0] seen = {bus.rdata[vlc_pkg::LS_SPG_BIT],
		bus.rdata[vlc_pkg::LS_IDG_BIT]};
	wire poll_end = seen == want || polls == POLL_LIMIT[$bits(polls)-1:0];

	assign bus.addr = (state == H_POLL) ? vlc_pkg::LINE_STATUS_ADDR : lat_addr;
	assign bus.wdata = lat_wdata;
	assign bus.wr = state == H_ISSUE && lat_wr;
	assign bus.rd = (state == H_ISSUE && !lat_wr) || state == H_POLL;
	assign avs_waitrequest = state != H_DONE;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= H_IDLE;
			lat_addr <= 7'h00;
			lat_wdata <= 8'h00;
			lat_wr <= 1'b0;
			want <= 2'b00;
			need_poll <= 1'b0;
			polls <= '0;
			confirmed <= 1'b0;
			timed_out <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			unique case (state)
				H_IDLE: begin
					if ((avs_read || avs_write) && own_hit) begin
						avs_readdata <= {30'h0, timed_out, confirmed};
						state <= H_DONE;
					end else if ((avs_read || avs_write) && !avs_address[7]) begin
						lat_addr <= avs_address[6:0];
						lat_wdata <= wd;
						lat_wr <= avs_write;
						need_poll <= avs_write && is_cmd && mode_cmd; // see RQ13
						want <= exp_mode;
						state <= H_ISSUE;
					end else if (avs_read || avs_write) begin
						avs_readdata <= 32'h0000_0000;
						state <= H_DONE;
					end
				end
				H_ISSUE: state <= H_WAIT;
				H_WAIT: begin
					if (bus.ack) begin
						avs_readdata <= {24'h00_0000, bus.rdata};
						polls <= '0;
						state <= need_poll ? H_POLL : H_DONE;
					end
				end
				H_POLL: state <= H_PWAIT;
				H_PWAIT: begin
					if (bus.ack) begin
						polls <= polls + 1'b1;
						if (poll_end) begin
							confirmed <= seen == want; // see RQ13
							timed_out <= seen != want;
							state <= H_DONE;
						end else begin
							state <= H_POLL;
						end
					end
				end
				H_DONE: state <= H_IDLE;
			endcase
		end
	end
endmodule

// ==== tb/vlc_asserts.sv ====
// Protocol checker for the register port between host and device
module vlc_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic ack
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire rd_cmd = rd && addr == vlc_pkg::COMMAND_ADDR;
	wire rd_lc = rd && addr == vlc_pkg::LINE_CONTROL_ADDR;
	wire rd_tc = rd && addr == vlc_pkg::TRANSMIT_CONTROL_ADDR;
	wire wr_cmd = wr && addr == vlc_pkg::COMMAND_ADDR;
	AST_ACK_NEXT: assert property ((wr || rd) |=> ack)
		else $error("no ack after strobe");
	AST_ACK_PULSE: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (ack |-> $past(wr || rd))
		else $error("ack without strobe");
	AST_ONE_DIR: assert property (!(wr && rd))
		else $error("read and write together");
	AST_CMD_RD_ZERO: assert property (rd_cmd |=> rdata == 8'h00)
		else $error("command read not zero");
	AST_ABSENT_ZERO: assert property (rd && addr > 7'h04 |=> !rdata)
		else $error("absent address read not zero");
	AST_VER_READ: assert property (rd_tc |=>
		rdata[3:1] == vlc_pkg::VERSION_CODE)
		else $error("version field wrong");
	AST_LC_RSV: assert property (rd_lc |=> !rdata[2])
		else $error("line control reserved bit set");
	AST_CMD_RSV_WR: assert property (wr_cmd |-> wdata[2:1] == 2'b00)
		else $error("command reserved bits written");
	AST_COV_CMD: cover property (wr_cmd);
	AST_COV_CMD_RD: cover property (rd_cmd);
	AST_COV_TC_RD: cover property (rd_tc);
endmodule

// ==== tb/van_line_control_registers_tb_top.sv ====
// Self-checking bench for the host controller and line controller pair
module van_line_control_registers_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0;
	logic rst = 1;
	logic [7:0] avs_address = 0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = 0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic rx_d = 0, rx_a = 0, rx_b = 0, sa = 0, sb = 0, sc = 0, tg = 0, rg = 0;
	logic tx_data = 0, tx_request = 0, eof_seen = 0;
	logic attempt_end = 0, attempt_ok = 0, attempt_error = 0;
	logic tx_line_out, tx_line_oe, rx_data_out, retry_exhausted, rearbitrate;
	logic module_type_sel, pulsed_coding_sel, timeslot_clock, tx_in_progress;
	logic sync_diagnosis_clock, return_to_idle_pulse, diagnosis_enable;
	logic general_reset_out, oscillator_run, sel_sdc = 0;
	logic [3:0] retry_count;
	logic [1:0] rx_source;
	logic [7:0] q;
	int err_total = 0, checks_done = 0, cyc = 0, seed, lc, tc, dc, cnt, n;
	int rpend = 0, global_reset_cmd_seen = 0;
	wire pick = sel_sdc ? sync_diagnosis_clock : timeslot_clock;
	vlc_if bus_if();
	vlc_host i_vlc_host (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .bus(bus_if.host_mp));
	vlc_device i_vlc_device (.clk(clk), .rst(rst), .bus(bus_if.dev_mp),
		.rx_differential_in(rx_d), .rx_single_wire_a_in(rx_a),
		.rx_single_wire_b_in(rx_b), .tx_line_out(tx_line_out),
		.tx_line_oe(tx_line_oe), .tx_data(tx_data), .tx_request(tx_request),
		.attempt_end(attempt_end), .attempt_ok(attempt_ok),
		.attempt_error(attempt_error), .eof_seen(eof_seen),
		.rx_data_out(rx_data_out), .retry_count(retry_count),
		.retry_exhausted(retry_exhausted), .rearbitrate(rearbitrate),
		.module_type_sel(module_type_sel),
		.pulsed_coding_sel(pulsed_coding_sel), .diag_sa(sa), .diag_sb(sb),
		.diag_sc(sc), .tx_going(tg), .rx_going(rg),
		.timeslot_clock(timeslot_clock),
		.sync_diagnosis_clock(sync_diagnosis_clock),
		.tx_in_progress(tx_in_progress),
		.return_to_idle_pulse(return_to_idle_pulse),
		.diagnosis_enable(diagnosis_enable), .rx_source(rx_source),
		.general_reset_out(general_reset_out),
		.oscillator_run(oscillator_run));
	vlc_asserts i_vlc_asserts (.clk(clk), .rst(rst), .addr(bus_if.addr),
		.wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
		.rdata(bus_if.rdata), .ack(bus_if.ack));
	always #2.5 clk = ~clk;
	// Line pins and diagnosis status wander randomly
	always @(posedge clk) begin
		{rx_d, rx_a, rx_b, sa, sb, sc, tg, rg} <= $random(seed);
		cyc <= cyc + 1;
		if (general_reset_out === 1'b1) global_reset_cmd_seen <= global_reset_cmd_seen + 1;
		if (cyc == 30000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One Avalon access; returns at the falling edge after release
	task automatic acc(input logic w, input int a, input int d);
		@(posedge clk);
		avs_address <= a[7:0];
		avs_writedata <= {24'h0000_00, d[7:0]};
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(negedge clk);
	endtask
	task automatic mwr(input int a, input int d);
		acc(1, a, d);
		if (a == 0) lc = d & 8'hfb;
		if (a == 1) tc = (d & 8'hf1) | (vlc_pkg::VERSION_CODE << 1);
		if (a == 2) dc = d & 8'hff;
	endtask
	task automatic regs_and_state(input logic [1:0] st);
		acc(0, 0, 0);
		chk(q, lc);
		acc(0, 1, 0);
		chk(q, tc);
		acc(0, 2, 0);
		chk(q, dc);
		acc(0, vlc_pkg::LINE_STATUS_ADDR, 0);
		chk(q[6:5], st);
	endtask
	task automatic cmd(input int b);
		acc(1, vlc_pkg::COMMAND_ADDR, 1 << b);
		repeat (2) @(negedge clk);
	endtask
	task automatic period(input int exp);
		n = 0;
		do @(negedge clk); while (pick !== 1'b1);
		do begin
			@(negedge clk);
			n++;
		end while (pick !== 1'b1);
		chk(n, exp);
	endtask
	task automatic att(input logic ok, input logic er);
		@(posedge clk);
		attempt_end <= 1'b1;
		attempt_ok <= ok;
		attempt_error <= er;
		@(posedge clk);
		attempt_end <= 1'b0;
		@(negedge clk);
		chk(rearbitrate, rpend != 0 && (ok || er || 1));
		chk(retry_exhausted, !rpend && !ok && er && cnt == tc >> 4);
		if (ok || rpend) cnt = 0;
		else if (er) cnt = (cnt == tc >> 4) ? 0 : cnt + 1;
		rpend = 0;
		chk(retry_count, cnt);
	endtask
	// Frame-side strobes, outputs checked after their register stage
	task automatic side(input int d, input logic eof);
		mwr(2, d);
		@(posedge clk);
		tx_request <= 1'b1;
		tx_data <= 1'b1;
		eof_seen <= eof;
		@(posedge clk);
		eof_seen <= 1'b0;
		@(negedge clk);
		chk(tx_in_progress, d[1] && !lc[3]);
		chk(return_to_idle_pulse, eof && d[3:2] != 3);
		chk(tx_line_out, !lc[1]);
	endtask
	initial begin
		seed = 32'hc5dc;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		lc = 0;
		tc = vlc_pkg::VERSION_CODE << 1;
		dc = 0;
		cnt = 0;
		regs_and_state(2'b01);
		chk(tx_line_oe, 0);
		repeat (12) mwr($unsigned($random(seed)) % 3, $random(seed));
		regs_and_state(2'b01);
		chk(module_type_sel, tc[0]);
		chk(diagnosis_enable, !lc[3]);
		acc(0, vlc_pkg::COMMAND_ADDR, 0);
		chk(q, 0);
		acc(0, 8'h10, 0);
		chk(q, 0);
		mwr(0, 8'h10);
		for (int m = 0; m < 3; m++) begin
			mwr(2, m << 2);
			chk(rx_source, m);
		end
		mwr(0, 8'h18);
		chk(rx_source, 0);
		chk(pulsed_coding_sel, 1);
		for (int k = 1; k < 4; k += 2) begin
			mwr(0, k << 4);
			period(16 * k);
		end
		mwr(0, 8'h10);
		sel_sdc = 1;
		for (int k = 0; k < 2; k++) begin
			mwr(2, (k << 4) | 1);
			period(1024 << k);
		end
		mwr(2, 0);
		repeat (1100) begin
			@(negedge clk);
			chk(pick, 0);
		end
		cmd(vlc_pkg::CMD_MANUAL_DIAG_CLOCK_PULSE_BIT);
		n = 0;
		while (pick === 1'b1) begin
			@(negedge clk);
			n++;
		end
		chk(n >= 20, 1);
		mwr(1, 8'h20);
		repeat (3) begin
			att(0, 1);
			att(0, 0);
		end
		att(0, 1);
		cmd(vlc_pkg::CMD_REAR_BIT);
		rpend = 1;
		att(0, 1);
		mwr(1, 0);
		att(0, 1);
		cmd(vlc_pkg::CMD_ACTIVATE_CMD_BIT);
		chk(tx_line_oe, 1);
		n = tx_line_out;
		mwr(0, 8'h12);
		chk(tx_line_out, !n[0]);
		regs_and_state(2'b00);
		cmd(vlc_pkg::CMD_SLEEP_BIT);
		chk(oscillator_run, 0);
		regs_and_state(2'b10);
		cmd(vlc_pkg::CMD_IDLE_BIT);
		chk(oscillator_run, 1);
		chk(tx_line_oe, 0);
		cmd(vlc_pkg::CMD_ACTIVATE_CMD_BIT);
		side(8'h02, 1);
		side(8'h0c, 1);
		mwr(2, 8'h5c);
		cmd(vlc_pkg::CMD_GLOBAL_RESET_CMD_BIT);
		lc = 0;
		tc = vlc_pkg::VERSION_CODE << 1;
		dc = 0;
		chk(tx_line_oe, 0);
		chk(rx_data_out, 1);
		chk(global_reset_cmd_seen, 1);
		regs_and_state(2'b01);
		tally_and_finish();
	end
endmodule
